// [design/dtd_decoder_map.svh]
// Purpose: Opcodes, field positions and clock counts of the data-transfer decoder
// Assumes: Included by its bare name from the decoder only
// Notes: Definitions only
`ifndef DTD_DECODER_MAP_SVH
`define DTD_DECODER_MAP_SVH

// ****************************************
// Opcode bytes
// ****************************************
`define DTD_OP_TABLE_LOOKUP_BYTE 8'hd7
`define DTD_OP_LOAD_EFF_OFFSET 8'h8d
`define DTD_OP_FAR_PTR_EXTRA_SEG 8'hc4
`define DTD_OP_FAR_PTR_DATA_SEG 8'hc5
`define DTD_OP_SWAP_OPERANDS 7'h43
`define DTD_OP_FLAGS_TO_HIGH_ACC 8'h9f
`define DTD_OP_HIGH_ACC_TO_FLAGS 8'h9e

// ****************************************
// Addressing-form byte fields
// ****************************************
`define DTD_MOD_HI 7
`define DTD_MOD_LO 6
`define DTD_REG_HI 5
`define DTD_REG_LO 3
`define DTD_RM_HI 2
`define DTD_RM_LO 0
`define DTD_MOD_REGISTER 2'h3

// ****************************************
// Execution clock counts and counter width
// ****************************************
`define DTD_CLK_TABLE_LOOKUP 15
`define DTD_CLK_LOAD_EFF 6
`define DTD_CLK_FAR_PTR 26
`define DTD_CLK_SWAP_REG 4
`define DTD_CLK_SWAP_MEM 17
`define DTD_CLK_FLAGS_TO_ACC 2
`define DTD_CLK_ACC_TO_FLAGS 3
`define DTD_CNT_W 5

`endif

// [design/dtd_pkg.sv]
// Purpose: Types shared by the data-transfer decoder and its bench
// Assumes: dtd_decoder_map.svh holds the numbers
// Notes: Types only
package dtd_pkg;

  // Instruction kinds of this group
  typedef enum logic [2:0] {
    DTD_NONE,
    DTD_TABLE_LOOKUP_BYTE,
    DTD_LOAD_EFFECTIVE_OFFSET,
    DTD_LOAD_FAR_POINTER_DATA_SEG,
    DTD_LOAD_FAR_POINTER_EXTRA_SEG,
    DTD_SWAP_OPERANDS,
    DTD_FLAGS_TO_HIGH_ACC,
    DTD_HIGH_ACC_TO_FLAGS
  } dtd_kind_t;

  // Decoded instruction handed to the execution unit
  typedef struct packed {
    dtd_kind_t kind;
    logic word;
    logic [1:0] mode;
    logic [2:0] reg_f;
    logic [2:0] rm;
    logic [4:0] clocks;
  } dtd_decode_t;

endpackage : dtd_pkg

// [design/dtd_decoder.sv]
// Purpose: Decode the data-transfer instruction group and time its execution
// Assumes: Opcode bytes come from fetch logic on core_clk, one per accepted handshake
// Notes: Opcodes outside the group are consumed and reported, not executed
`timescale 1ns/10ps
`include "dtd_decoder_map.svh"

// Summary of operation
// - Byte 11010111 decodes as table_lookup_byte and runs for 15 clocks.
// - Byte 10001101 plus an addressing byte with form other than 11 is load_effective_offset.
// - Byte 11000100 plus a memory-form addressing byte is load_far_pointer_extra_seg, 26 clocks.
// - load_far_pointer_data_seg takes only memory forms and runs for 26 clocks.
// - Bytes 1000011w plus addressing byte are swap_operands, w sets size, 4 or 17 clocks.
// - Byte 10011111 is flags_to_high_acc and runs for 2 clocks.
// - Byte 10011110 is high_acc_to_flags and runs for 3 clocks.
module dtd_decoder
  import dtd_pkg::*;
#(
  parameter int CNT_W = `DTD_CNT_W,
  parameter int CLK_LOAD_EFF = `DTD_CLK_LOAD_EFF,
  parameter logic [7:0] OP_FAR_PTR_DATA_SEG = `DTD_OP_FAR_PTR_DATA_SEG
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic op_valid,
  input wire logic [7:0] op_byte,
  output logic op_ready,
  output logic dec_valid,
  output dtd_decode_t dec_info,
  output logic bad_form,
  output logic not_group,
  output logic exec_busy,
  output logic exec_done
);

  // ****************************************
  // Parameter checks
  // ****************************************
  // Counter must hold the longest count; struct field is fixed at 5 bits
  if (CNT_W != 5) begin : g_bad_cnt
    $error("dtd_decoder: CNT_W must be 5");
  end
  if (CLK_LOAD_EFF < 1 || CLK_LOAD_EFF > 31) begin : g_bad_eff
    $error("dtd_decoder: CLK_LOAD_EFF out of range");
  end
  // A data-segment opcode that aliases another of the group would leave one of the two never decoding
  if (OP_FAR_PTR_DATA_SEG == `DTD_OP_TABLE_LOOKUP_BYTE ||
      OP_FAR_PTR_DATA_SEG == `DTD_OP_LOAD_EFF_OFFSET ||
      OP_FAR_PTR_DATA_SEG == `DTD_OP_FAR_PTR_EXTRA_SEG ||
      OP_FAR_PTR_DATA_SEG[7:1] == `DTD_OP_SWAP_OPERANDS ||
      OP_FAR_PTR_DATA_SEG == `DTD_OP_FLAGS_TO_HIGH_ACC ||
      OP_FAR_PTR_DATA_SEG == `DTD_OP_HIGH_ACC_TO_FLAGS) begin : g_bad_op
    $error("dtd_decoder: OP_FAR_PTR_DATA_SEG collides with another opcode");
  end

  localparam logic [4:0] C_TLB = 5'(`DTD_CLK_TABLE_LOOKUP);
  localparam logic [4:0] C_LEO = 5'(CLK_LOAD_EFF);
  localparam logic [4:0] C_FAR = 5'(`DTD_CLK_FAR_PTR);
  localparam logic [4:0] C_SWR = 5'(`DTD_CLK_SWAP_REG);
  localparam logic [4:0] C_SWM = 5'(`DTD_CLK_SWAP_MEM);
  localparam logic [4:0] C_F2A = 5'(`DTD_CLK_FLAGS_TO_ACC);
  localparam logic [4:0] C_A2F = 5'(`DTD_CLK_ACC_TO_FLAGS);

  typedef enum logic [1:0] {S_IDLE, S_FORM, S_EXEC} dtd_state_t;

  // ****************************************
  // Decode functions
  // ****************************************
  // Opcode byte to kind; used for first byte and held opcode
  function automatic dtd_kind_t kind_of(input logic [7:0] op);
    dtd_kind_t k;
    k = DTD_NONE;
    if (op == `DTD_OP_TABLE_LOOKUP_BYTE) k = DTD_TABLE_LOOKUP_BYTE;
    else if (op == `DTD_OP_LOAD_EFF_OFFSET) k = DTD_LOAD_EFFECTIVE_OFFSET;
    else if (op == `DTD_OP_FAR_PTR_EXTRA_SEG) k = DTD_LOAD_FAR_POINTER_EXTRA_SEG;
    else if (op == OP_FAR_PTR_DATA_SEG) k = DTD_LOAD_FAR_POINTER_DATA_SEG;
    else if (op[7:1] == `DTD_OP_SWAP_OPERANDS) k = DTD_SWAP_OPERANDS;
    else if (op == `DTD_OP_FLAGS_TO_HIGH_ACC) k = DTD_FLAGS_TO_HIGH_ACC;
    else if (op == `DTD_OP_HIGH_ACC_TO_FLAGS) k = DTD_HIGH_ACC_TO_FLAGS;
    return k;
  endfunction : kind_of

  // Kinds that carry an addressing-form byte
  function automatic logic has_form(input dtd_kind_t k);
    return k == DTD_LOAD_EFFECTIVE_OFFSET || k == DTD_LOAD_FAR_POINTER_EXTRA_SEG ||
           k == DTD_LOAD_FAR_POINTER_DATA_SEG || k == DTD_SWAP_OPERANDS;
  endfunction : has_form

  // Kinds that must name a memory operand
  function automatic logic mem_only(input dtd_kind_t k);
    return has_form(k) && k != DTD_SWAP_OPERANDS;
  endfunction : mem_only

  // Execution clocks per kind and form
  function automatic logic [4:0] clocks_of(input dtd_kind_t k, input logic [1:0] md);
    logic [4:0] c;
    c = 5'h01;
    case (k)
      DTD_TABLE_LOOKUP_BYTE: c = C_TLB;
      DTD_LOAD_EFFECTIVE_OFFSET: c = C_LEO;
      DTD_LOAD_FAR_POINTER_EXTRA_SEG: c = C_FAR;
      DTD_LOAD_FAR_POINTER_DATA_SEG: c = C_FAR;
      DTD_SWAP_OPERANDS: c = (md == `DTD_MOD_REGISTER) ? C_SWR : C_SWM;
      DTD_FLAGS_TO_HIGH_ACC: c = C_F2A;
      DTD_HIGH_ACC_TO_FLAGS: c = C_A2F;
      default: c = 5'h01;
    endcase
    return c;
  endfunction : clocks_of

  // ****************************************
  // State
  // ****************************************
  dtd_state_t state;
  logic [7:0] opc_q;
  logic [4:0] cnt;

  // ****************************************
  // Next-value decoding
  // ****************************************
  // Byte is taken only while not executing and the clock enable is high
  wire take = clk_en && op_valid && op_ready;
  wire [1:0] byte_mode = op_byte[`DTD_MOD_HI:`DTD_MOD_LO];
  wire dtd_kind_t first_kind = kind_of(op_byte);
  wire dtd_kind_t held_kind = kind_of(opc_q);
  wire take_first = take && state == S_IDLE;
  wire take_form = take && state == S_FORM;
  wire form_reject = take_form && mem_only(held_kind) && byte_mode == `DTD_MOD_REGISTER;
  wire first_unknown = take_first && first_kind == DTD_NONE;
  wire first_single = take_first && first_kind != DTD_NONE && !has_form(first_kind);
  wire first_formed = take_first && has_form(first_kind);
  wire issue_form = take_form && !form_reject;
  wire issue = first_single || issue_form;
  wire exec_last = clk_en && state == S_EXEC && cnt == 5'h00;

  // Decoded word: single-byte opcodes report zero fields
  dtd_decode_t next_info;
  assign next_info.kind = first_single ? first_kind : held_kind;
  assign next_info.word = first_single ? 1'b0 : opc_q[0];
  assign next_info.mode = first_single ? 2'h0 : byte_mode;
  assign next_info.reg_f = first_single ? 3'h0 : op_byte[`DTD_REG_HI:`DTD_REG_LO];
  assign next_info.rm = first_single ? 3'h0 : op_byte[`DTD_RM_HI:`DTD_RM_LO];
  assign next_info.clocks = clocks_of(next_info.kind, next_info.mode);

  dtd_state_t next_state;
  assign next_state = issue ? S_EXEC :
                      first_formed ? S_FORM :
                      (form_reject || exec_last) ? S_IDLE : state;

  // Handshake is combinational so fetch can stream back to back
  assign op_ready = state != S_EXEC;
  assign exec_busy = state == S_EXEC;

  // ****************************************
  // Registers
  // ****************************************
  // Sequencer and execution counter
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state <= S_IDLE;
      cnt <= 5'h00;
      opc_q <= 8'h00;
    end else if (clk_en) begin
      state <= next_state;
      if (first_formed) opc_q <= op_byte;
      if (issue) cnt <= next_info.clocks - 5'h01;
      else if (state == S_EXEC) cnt <= cnt - 5'h01;
    end
  end

  // Output strobes and decoded word; rejected forms never reach execution
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      dec_valid <= 1'b0;
      dec_info <= '0;
      bad_form <= 1'b0;
      not_group <= 1'b0;
      exec_done <= 1'b0;
    end else if (clk_en) begin
      dec_valid <= issue;
      if (issue) dec_info <= next_info;
      bad_form <= form_reject;
      not_group <= first_unknown;
      exec_done <= exec_last;
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst || !clk_en);

  // Length of the current execution run
  logic [4:0] run_len;
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) run_len <= 5'h00;
    else if (clk_en) run_len <= exec_busy ? run_len + 5'h01 : 5'h00;
  end

  sequence s_take(logic [7:0] op);
    take_first && op_byte == op;
  endsequence

  sequence s_issued(dtd_kind_t k, logic [4:0] c);
    dec_valid && exec_busy && dec_info.kind == k && dec_info.clocks == c;
  endsequence

  lookup_op_a: assert property (s_take(8'hd7) |=> s_issued(DTD_TABLE_LOOKUP_BYTE, 5'h0f))
    else $error("table lookup byte not issued with 15 clocks");
  run_length_a: assert property (exec_done |-> run_len == dec_info.clocks)
    else $error("execution run length differs from decoded clocks");
  offset_load_a: assert property (take_form && opc_q == 8'h8d && byte_mode != 2'h3
                                  |=> dec_valid && dec_info.kind == DTD_LOAD_EFFECTIVE_OFFSET)
    else $error("effective offset load not issued");
  far_extra_a: assert property (take_form && opc_q == 8'hc4 && byte_mode != 2'h3
                                |=> s_issued(DTD_LOAD_FAR_POINTER_EXTRA_SEG, 5'h1a))
    else $error("far pointer extra segment load wrong");
  far_data_a: assert property (take_form && opc_q == OP_FAR_PTR_DATA_SEG && byte_mode != 2'h3
                               |=> s_issued(DTD_LOAD_FAR_POINTER_DATA_SEG, 5'h1a))
    else $error("far pointer data segment load wrong");
  swap_form_a: assert property (take_form && opc_q[7:1] == 7'h43
                                |=> dec_valid && dec_info.word == $past(opc_q[0]) &&
                                    dec_info.clocks == ($past(byte_mode) == 2'h3 ? 5'h04 : 5'h11))
    else $error("swap size or clocks wrong");
  flags_acc_a: assert property (s_take(8'h9f) |=> dec_valid ##0 exec_busy [*2] ##1 exec_done)
    else $error("flags to high byte not two clocks");
  acc_flags_a: assert property (s_take(8'h9e) |=> dec_valid ##0 exec_busy [*3] ##1 exec_done)
    else $error("high byte to flags not three clocks");
  bad_form_a: assert property (form_reject |=> bad_form && !dec_valid && !exec_busy)
    else $error("register form not rejected");

endmodule : dtd_decoder

// [test/dtd_decoder_tb.sv]
// Purpose: Self-checking bench for the data-transfer decoder
// Assumes: Inputs change on the rising edge of core_clk; outputs are read 1 ns later
// Notes: Ready is read 1 ns after an edge, where it stands until the next edge
`timescale 1ns/10ps
module testbench;
  import dtd_pkg::*;
  // ****************************************
  // Signals and design
  // ****************************************
  localparam int EFF_CLK = 6;
  localparam int MAX_CYC = 3000;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic clk_en = 1'b1;
  logic op_valid = 1'b0;
  logic [7:0] op_byte = 8'h00;
  logic op_ready, dec_valid, bad_form, not_group, exec_busy, exec_done;
  dtd_decode_t dec_info;
  int n_mismatch = 0;
  int n_compared = 0;
  int cyc = 0;

  dtd_decoder #(.CLK_LOAD_EFF(EFF_CLK)) dtd_decoder_inst (
    .core_clk(core_clk), .rst(rst), .clk_en(clk_en), .op_valid(op_valid),
    .op_byte(op_byte), .op_ready(op_ready), .dec_valid(dec_valid), .dec_info(dec_info),
    .bad_form(bad_form), .not_group(not_group), .exec_busy(exec_busy),
    .exec_done(exec_done)
  );

  // 50 ns period
  always #25 core_clk = ~core_clk;

  // Hang guard; the whole run needs under two hundred cycles
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == MAX_CYC) begin
      n_mismatch = n_mismatch + 1;
      report_and_stop();
    end
  end

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic report_and_stop();
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : report_and_stop

  task automatic chk(input bit ok, input string msg);
    n_compared++;
    if (!ok) begin
      n_mismatch++;
      $display("[FAIL] %0t %s", $time, msg);
    end
  endtask : chk

  // Offer one byte and hold it until an edge that sees ready high
  task automatic send(input logic [7:0] b);
    int n;
    logic rdy;
    @(posedge core_clk);
    op_valid <= 1'b1;
    op_byte <= b;
    n = 0;
    do begin
      // Ready only moves on an edge, so its settled value is what the next edge sees
      #1;
      rdy = op_ready;
      @(posedge core_clk);
      n++;
    end while (rdy !== 1'b1 && n < 100);
    op_valid <= 1'b0;
    chk(n < 100, "byte never taken");
  endtask : send

  // Judge the issue, then count busy cycles until done
  task automatic expect_exec(input dtd_kind_t k, input logic w, input logic [7:0] fb,
      input bit two, input int clks);
    int n;
    #1;
    chk(dec_valid === 1'b1 && dec_info.kind === k && dec_info.clocks === 5'(clks), "issue");
    if (two) begin
      chk(dec_info.word === w && {dec_info.mode, dec_info.reg_f, dec_info.rm} === fb, "fields");
    end
    n = 0;
    while (exec_busy === 1'b1 && n < 40) begin
      chk(op_ready === 1'b0, "ready while busy");
      if (n == 1) begin
        chk(dec_valid === 1'b0, "issue strobe longer than one cycle");
      end
      n++;
      @(posedge core_clk);
      #1;
    end
    chk(n == clks && exec_done === 1'b1, "exec length");
  endtask : expect_exec

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_single();
    send(8'hd7);
    expect_exec(DTD_TABLE_LOOKUP_BYTE, 1'b0, 8'h00, 1'b0, 15);
    send(8'h9f);
    expect_exec(DTD_FLAGS_TO_HIGH_ACC, 1'b0, 8'h00, 1'b0, 2);
    send(8'h9e);
    expect_exec(DTD_HIGH_ACC_TO_FLAGS, 1'b0, 8'h00, 1'b0, 3);
  endtask : t_single

  // Register form is the short case, memory form the long one
  task automatic t_swap();
    send(8'h86);
    send(8'hc1);
    expect_exec(DTD_SWAP_OPERANDS, 1'b0, 8'hc1, 1'b1, 4);
    send(8'h87);
    send(8'h46);
    expect_exec(DTD_SWAP_OPERANDS, 1'b1, 8'h46, 1'b1, 17);
  endtask : t_swap

  // Size bit follows opcode bit 0 for every two-byte opcode
  task automatic t_memory();
    send(8'h8d);
    send(8'h5e);
    expect_exec(DTD_LOAD_EFFECTIVE_OFFSET, 1'b1, 8'h5e, 1'b1, EFF_CLK);
    send(8'hc4);
    send(8'h87);
    expect_exec(DTD_LOAD_FAR_POINTER_EXTRA_SEG, 1'b0, 8'h87, 1'b1, 26);
    send(8'hc5);
    send(8'h0e);
    expect_exec(DTD_LOAD_FAR_POINTER_DATA_SEG, 1'b1, 8'h0e, 1'b1, 26);
  endtask : t_memory

  // Register form on a memory-only opcode is dropped, nothing runs
  task automatic t_bad_form(input logic [7:0] op);
    send(op);
    send(8'hda);
    #1;
    chk(bad_form === 1'b1 && dec_valid === 1'b0, "form not refused");
    @(posedge core_clk);
    #1;
    chk(bad_form === 1'b0 && exec_busy === 1'b0 && op_ready === 1'b1, "ran after refusal");
  endtask : t_bad_form

  task automatic t_not_group();
    send(8'h00);
    #1;
    chk(not_group === 1'b1 && dec_valid === 1'b0 && exec_busy === 1'b0, "foreign byte");
  endtask : t_not_group

  // Enable low must freeze the count, not lose it
  task automatic t_freeze();
    int n;
    send(8'h9e);
    @(posedge core_clk);
    clk_en <= 1'b0;
    repeat (4) @(posedge core_clk);
    #1;
    chk(exec_busy === 1'b1 && exec_done === 1'b0, "freeze");
    @(posedge core_clk);
    clk_en <= 1'b1;
    n = 0;
    while (exec_done !== 1'b1 && n < 10) begin
      @(posedge core_clk);
      #1;
      n++;
    end
    chk(exec_done === 1'b1, "resume");
  endtask : t_freeze

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    repeat (12) @(posedge core_clk);
    rst <= 1'b0;
    #1;
    chk(op_ready === 1'b1 && exec_busy === 1'b0 && dec_info === '0, "reset state");
    t_single();
    t_swap();
    t_memory();
    t_bad_form(8'h8d);
    t_bad_form(8'hc4);
    t_bad_form(8'hc5);
    t_not_group();
    t_freeze();
    report_and_stop();
  end
endmodule : testbench
